// ---- hw/rps_params.svh ----
// Command codes, status bit positions, limits and reset values of the command/status block
`ifndef RPS_PARAMS_SVH
`define RPS_PARAMS_SVH

`define RPS_CMD_CLEAR 8'h03
`define RPS_CMD_VOUT 8'h21
`define RPS_CMD_OVLIM 8'h40
`define RPS_CMD_RDSTAT 8'hd0

`define RPS_ADDR_PREFIX 4'h8
`define RPS_ADDR_BCAST 8'h00
`define RPS_CRC_POLY 8'h07
`define RPS_BLOCK_COUNT 8'h09
`define RPS_PEC_IDX 4'h9

// Set point codes, volts times 400
`define RPS_VOUT_MIN_CODE 16'h41a0
`define RPS_VOUT_MAX_CODE 16'h5aa0
`define RPS_OV_RST 16'h5dc0

// Byte counts after the address byte, checksum included except in the command-only count
`define RPS_LEN_NODATA 4'h2
`define RPS_LEN_WORD 4'h4
`define RPS_LEN_CMDONLY 4'h1

// Status-two bits
`define RPS_S2_PEC 7
`define RPS_S2_WILLRST 6
`define RPS_S2_INVCMD 5
`define RPS_S2_HIGHLINE 4
`define RPS_S2_ISOFAIL 3
`define RPS_S2_RESTARTED 2
`define RPS_S2_RANGE 1
`define RPS_S2_ENPIN 0

// Status-one bits
`define RPS_S1_ISOOK 6
`define RPS_S1_INTFLT 5
`define RPS_S1_SHUTDOWN 4
`define RPS_S1_SVCLED 3
`define RPS_S1_EXTFLT 2
`define RPS_S1_LEDTEST 1
`define RPS_S1_OUTON 0

`endif

// ---- hw/rps_pkg.sv ----
// Types of the command/status block
package rps_pkg;
  typedef enum logic [2:0] {
    RPS_IDLE = 3'b000,
    RPS_ADDR = 3'b001,
    RPS_WR = 3'b011,
    RPS_RD = 3'b010,
    RPS_IGN = 3'b110
  } rps_state_e;
endpackage : rps_pkg

// ---- hw/rps_cmd_status.sv ----
// Management-port command interpreter and status registers of the rectifier
`timescale 1ns/1ps
`include "rps_params.svh"

module rps_cmd_status #(
  parameter int VOUT_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_oe_o,
  input wire logic [2:0] addr_sel_i,
  input wire logic enable_pin_i,
  input wire logic [15:0] default_vout_i,
  input wire logic will_restart_i,
  input wire logic high_line_i,
  input wire logic int_fault_i,
  input wire logic svc_led_i,
  input wire logic ext_fault_i,
  input wire logic led_test_i,
  input wire logic out_on_i,
  input wire logic shutdown_evt_i,
  input wire logic restart_done_i,
  input wire logic iso_pass_i,
  input wire logic iso_fail_i,
  input wire logic [7:0] alarm_one_i,
  input wire logic [7:0] alarm_two_i,
  input wire logic [15:0] meas_vout_i,
  input wire logic [7:0] meas_curr_i,
  input wire logic [7:0] meas_temp_i,
  output logic [15:0] vout_set_o,
  output logic [15:0] ov_limit_o,
  output logic sw_setpoint_o
);

  if (VOUT_W != 16) begin : g_width_check
    $error("VOUT_W must be 16");
  end

  function automatic logic [7:0] rps_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ `RPS_CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : rps_crc8

  // Link domain: bits shift in on the bus clock; word is read only after a synced rise
  logic [7:0] rx_shift_ff;
  always_ff @(posedge scl_i) begin
    rx_shift_ff <= {rx_shift_ff[6:0], sda_i};
  end

  // Pin synchronisers
  logic scl_s1_ff, scl_s2_ff, scl_q_ff, sda_s1_ff, sda_s2_ff, sda_q_ff;
  logic en_s1_ff, en_s2_ff;
  logic [2:0] as_s1_ff, as_s2_ff;
  always_ff @(posedge ref_clk_i) begin
    scl_s1_ff <= scl_i;
    scl_s2_ff <= scl_s1_ff;
    scl_q_ff <= scl_s2_ff;
    sda_s1_ff <= sda_i;
    sda_s2_ff <= sda_s1_ff;
    sda_q_ff <= sda_s2_ff;
    en_s1_ff <= enable_pin_i;
    en_s2_ff <= en_s1_ff;
    as_s1_ff <= addr_sel_i;
    as_s2_ff <= as_s1_ff;
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_ff & ~scl_q_ff;
  assign scl_fall = ~scl_s2_ff & scl_q_ff;
  assign bus_start = scl_s2_ff & scl_q_ff & sda_q_ff & ~sda_s2_ff;
  assign bus_stop = scl_s2_ff & scl_q_ff & ~sda_q_ff & sda_s2_ff;

  rps_pkg::rps_state_e state_ff;
  logic [3:0] bit_ff, n_ff, ridx_ff;
  logic [7:0] cmd_ff, dlo_ff, dhi_ff, crc_ff, tx_ff;
  logic ack_ff;

  // Status storage
  logic pec_err_ff, inv_cmd_ff, iso_fail_ff, restarted_ff, range_ff, iso_ok_ff, shutdown_ff;
  logic [7:0] alarm_one_ff, alarm_two_ff;
  logic [15:0] vout_sw_ff;
  logic sw_prog_ff;
  logic [7:0] status_two, status_one;

  assign status_two = {pec_err_ff, will_restart_i, inv_cmd_ff, high_line_i,
                       iso_fail_ff, restarted_ff, range_ff, en_s2_ff};
  assign status_one = {1'b0, iso_ok_ff, int_fault_i, shutdown_ff,
                       svc_led_i, ext_fault_i, led_test_i, out_on_i};

  function automatic logic [7:0] rps_resp(input logic [3:0] idx, input logic [7:0] s2,
                                          input logic [7:0] s1, input logic [7:0] a2,
                                          input logic [7:0] a1, input logic [15:0] v,
                                          input logic [7:0] c, input logic [7:0] t);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      4'h0: b = `RPS_BLOCK_COUNT;
      4'h1: b = s2;
      4'h2: b = s1;
      4'h3: b = a2;
      4'h4: b = a1;
      4'h5: b = v[7:0];
      4'h6: b = v[15:8];
      4'h7: b = c;
      4'h8: b = t;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : rps_resp

  // Command execution at the end of a write phase
  logic exec_go, pec_ok, do_clear, do_vout, do_ov, set_pec, set_range, set_inv;
  logic [15:0] data_word;
  logic vout_ok;
  assign exec_go = (bus_stop | bus_start) & (state_ff == rps_pkg::RPS_WR);
  assign pec_ok = (crc_ff == 8'h00);
  assign data_word = {dhi_ff, dlo_ff};
  assign vout_ok = (data_word >= `RPS_VOUT_MIN_CODE) && (data_word <= `RPS_VOUT_MAX_CODE);

  always_comb begin
    do_clear = 1'b0;
    do_vout = 1'b0;
    do_ov = 1'b0;
    set_pec = 1'b0;
    set_range = 1'b0;
    set_inv = 1'b0;
    if (exec_go && n_ff != 4'h0) begin
      case (cmd_ff)
        `RPS_CMD_CLEAR: begin
          if (n_ff != `RPS_LEN_NODATA) set_range = 1'b1;
          else if (!pec_ok) set_pec = 1'b1;
          else do_clear = 1'b1;
        end
        `RPS_CMD_VOUT, `RPS_CMD_OVLIM: begin
          if (n_ff != `RPS_LEN_WORD) set_range = 1'b1;
          else if (!pec_ok) set_pec = 1'b1;
          else if (cmd_ff == `RPS_CMD_OVLIM) do_ov = 1'b1;
          else if (vout_ok) do_vout = 1'b1;
          else set_range = 1'b1;
        end
        `RPS_CMD_RDSTAT: begin
          if (n_ff != `RPS_LEN_CMDONLY || !bus_start) set_range = 1'b1;
        end
        default: set_inv = 1'b1;
      endcase
    end
  end

  // Bus transaction sequencer
  logic addr_match, addr_bcast;
  assign addr_match = (rx_shift_ff[7:1] == {`RPS_ADDR_PREFIX, as_s2_ff});
  assign addr_bcast = (rx_shift_ff == `RPS_ADDR_BCAST);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= rps_pkg::RPS_IDLE;
      bit_ff <= 4'h0;
      n_ff <= 4'h0;
      ridx_ff <= 4'h0;
      cmd_ff <= 8'h00;
      dlo_ff <= 8'h00;
      dhi_ff <= 8'h00;
      crc_ff <= 8'h00;
      tx_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else if (bus_stop) begin
      state_ff <= rps_pkg::RPS_IDLE;
      ack_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff <= rps_pkg::RPS_ADDR;
      bit_ff <= 4'h0;
      ack_ff <= 1'b0;
      if (state_ff == rps_pkg::RPS_IDLE) begin
        n_ff <= 4'h0;
        crc_ff <= 8'h00;
      end
    end else if (scl_rise && state_ff != rps_pkg::RPS_IDLE) begin
      if (bit_ff == 4'h8) begin
        bit_ff <= 4'h0;
        ack_ff <= 1'b0;
        if (state_ff == rps_pkg::RPS_RD && !ack_ff) begin // Own address ack is not a host ack
          if (sda_s2_ff || ridx_ff == `RPS_PEC_IDX) begin
            state_ff <= rps_pkg::RPS_IGN;
          end else begin
            ridx_ff <= ridx_ff + 4'h1;
            if (ridx_ff + 4'h1 == `RPS_PEC_IDX) begin
              tx_ff <= crc_ff;
            end else begin
              tx_ff <= rps_resp(ridx_ff + 4'h1, status_two, status_one, alarm_two_ff,
                                alarm_one_ff, meas_vout_i, meas_curr_i, meas_temp_i);
              crc_ff <= rps_crc8(crc_ff, rps_resp(ridx_ff + 4'h1, status_two, status_one,
                                 alarm_two_ff, alarm_one_ff, meas_vout_i, meas_curr_i,
                                 meas_temp_i));
            end
          end
        end
      end else if (bit_ff == 4'h7) begin
        bit_ff <= 4'h8;
        case (state_ff)
          rps_pkg::RPS_ADDR: begin
            crc_ff <= rps_crc8(crc_ff, rx_shift_ff);
            if (!rx_shift_ff[0] && (addr_match || addr_bcast)) begin
              state_ff <= rps_pkg::RPS_WR;
              n_ff <= 4'h0;
              ack_ff <= 1'b1;
            end else if (rx_shift_ff[0] && addr_match && cmd_ff == `RPS_CMD_RDSTAT
                         && n_ff == `RPS_LEN_CMDONLY) begin
              state_ff <= rps_pkg::RPS_RD;
              ack_ff <= 1'b1;
              ridx_ff <= 4'h0;
              tx_ff <= `RPS_BLOCK_COUNT;
              crc_ff <= rps_crc8(rps_crc8(crc_ff, rx_shift_ff), `RPS_BLOCK_COUNT);
            end else begin
              state_ff <= rps_pkg::RPS_IGN;
            end
          end
          rps_pkg::RPS_WR: begin
            crc_ff <= rps_crc8(crc_ff, rx_shift_ff);
            ack_ff <= 1'b1;
            if (n_ff != 4'hf) n_ff <= n_ff + 4'h1;
            if (n_ff == 4'h0) cmd_ff <= rx_shift_ff;
            if (n_ff == 4'h1) dlo_ff <= rx_shift_ff;
            if (n_ff == 4'h2) dhi_ff <= rx_shift_ff;
          end
          default: ack_ff <= 1'b0;
        endcase
      end else begin
        bit_ff <= bit_ff + 4'h1;
      end
    end
  end

  // Data line driver, changes after a clock fall, and is released at a start or stop
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (bus_start || bus_stop) begin
      sda_oe_o <= 1'b0;
    end else if (scl_fall) begin
      if (bit_ff == 4'h8) sda_oe_o <= ack_ff;
      else if (state_ff == rps_pkg::RPS_RD) sda_oe_o <= ~tx_ff[~bit_ff[2:0]];
      else sda_oe_o <= 1'b0;
    end
  end

  // Status flags: a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pec_err_ff <= 1'b0;
      inv_cmd_ff <= 1'b0;
      alert_oe_o <= 1'b0;
      range_ff <= 1'b0;
      iso_fail_ff <= 1'b0;
      iso_ok_ff <= 1'b0;
      restarted_ff <= 1'b0;
    end else begin
      pec_err_ff <= (pec_err_ff & ~do_clear) | set_pec;
      inv_cmd_ff <= (inv_cmd_ff & ~do_clear) | set_inv;
      alert_oe_o <= (alert_oe_o & ~do_clear) | set_inv;
      // Stored set point is always in range, so a clear or an accepted set point write drops the flag
      range_ff <= (range_ff & ~do_clear & ~do_vout) | set_range;
      iso_fail_ff <= (iso_fail_ff & ~do_clear) | iso_fail_i;
      iso_ok_ff <= (iso_ok_ff & ~do_clear) | iso_pass_i;
      restarted_ff <= (restarted_ff & ~do_clear) | restart_done_i;
    end
  end

  // Alarms and latched shutdown, wiped by a successful restart
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      alarm_one_ff <= 8'h00;
      alarm_two_ff <= 8'h00;
      shutdown_ff <= 1'b0;
    end else begin
      alarm_one_ff <= (alarm_one_ff & {8{~restart_done_i}}) | alarm_one_i;
      alarm_two_ff <= (alarm_two_ff & {8{~restart_done_i}}) | alarm_two_i;
      shutdown_ff <= (shutdown_ff & ~restart_done_i) | shutdown_evt_i;
    end
  end

  // Set points; software ownership only ends with a power-down reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      vout_sw_ff <= 16'h0000;
      sw_prog_ff <= 1'b0;
      ov_limit_o <= `RPS_OV_RST;
      vout_set_o <= 16'h0000;
      sw_setpoint_o <= 1'b0;
    end else begin
      if (do_vout) begin
        vout_sw_ff <= data_word;
        sw_prog_ff <= 1'b1;
      end
      if (do_ov) ov_limit_o <= data_word;
      vout_set_o <= sw_prog_ff ? vout_sw_ff : default_vout_i;
      sw_setpoint_o <= sw_prog_ff;
    end
  end

  default clocking rps_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence rps_vout_cmd_s;
    do_vout ##1 sw_prog_ff;
  endsequence

  pec_flag_set_a: assert property (set_pec |=> pec_err_ff)
    else $error("checksum error not flagged");
  flags_cleared_a: assert property (do_clear && !set_inv && !iso_fail_i && !iso_pass_i
      && !restart_done_i |=> !inv_cmd_ff && !iso_fail_ff && !iso_ok_ff && !restarted_ff)
    else $error("clear command left a flag set");
  vout_applied_a: assert property (rps_vout_cmd_s |=> vout_set_o == $past(data_word, 2))
    else $error("set point not applied");
  vout_in_range_a: assert property (sw_setpoint_o |-> vout_set_o >= `RPS_VOUT_MIN_CODE
      && vout_set_o <= `RPS_VOUT_MAX_CODE)
    else $error("set point outside range");
  sw_owner_sticky_a: assert property (sw_setpoint_o |=> sw_setpoint_o)
    else $error("software ownership dropped");
  invalid_alert_a: assert property (set_inv |=> alert_oe_o && status_two[`RPS_S2_INVCMD])
    else $error("unknown code not flagged");
  restart_clear_a: assert property (restart_done_i && alarm_one_i == 8'h00 && !shutdown_evt_i
      |=> alarm_one_ff == 8'h00 && !shutdown_ff && restarted_ff)
    else $error("restart did not clear alarms");
  count_first_a: assert property ($rose(state_ff == rps_pkg::RPS_RD)
      |-> tx_ff == `RPS_BLOCK_COUNT && ridx_ff == 4'h0)
    else $error("block read does not open with count");
  enable_mirror_a: assert property (##2 status_two[`RPS_S2_ENPIN] == $past(enable_pin_i, 2))
    else $error("enable bit does not follow pin");
  host_nack_end_a: assert property (state_ff == rps_pkg::RPS_RD && scl_rise && !bus_start
      && !bus_stop && bit_ff == 4'h8 && sda_s2_ff |=> state_ff == rps_pkg::RPS_IGN)
    else $error("read continued after nack");

endmodule : rps_cmd_status

// ---- dv/rps_host_model.sv ----
// Bus host model: start, repeated start, stop, byte transfers, running checksum
`timescale 1ns/1ps
module rps_host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  logic [7:0] crc;

  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
    crc = 8'h00;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt

  // Covers every byte seen on the wire, both directions
  task automatic upd(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      crc = {crc[6:0], 1'b0} ^ (((crc[7] ^ b[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
  endtask : upd

  task automatic start();
    crc = 8'h00;
    sda_pull_o <= 1'b1;
    wt(125);
    scl_o <= 1'b0;
  endtask : start

  task automatic rstart();
    wt(62);
    sda_pull_o <= 1'b0;
    wt(63);
    scl_o <= 1'b1;
    wt(125);
    sda_pull_o <= 1'b1;
    wt(125);
    scl_o <= 1'b0;
  endtask : rstart

  task automatic stop();
    wt(62);
    sda_pull_o <= 1'b1;
    wt(63);
    scl_o <= 1'b1;
    wt(125);
    sda_pull_o <= 1'b0;
    wt(125);
  endtask : stop

  // Data moves only mid-low so it never looks like a start or stop
  task automatic bit_io(input logic v, output logic s);
    wt(62);
    sda_pull_o <= ~v;
    wt(63);
    scl_o <= 1'b1;
    wt(125);
    s = sda_i;
    scl_o <= 1'b0;
  endtask : bit_io

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
    upd(b);
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
    upd(b);
  endtask : rbyte
endmodule : rps_host_model

// ---- dv/rps_tb.sv ----
// Self-checking bench of the command/status block
`timescale 1ns/1ps
`include "rps_params.svh"
module testbench;
  logic ref_clk_i, rst_n_i, scl, sda_pull, sda_w;
  logic sda_o, sda_oe_o, alert_oe_o, sw_setpoint_o;
  logic [2:0] addr_sel_i;
  logic enable_pin_i, will_restart_i, high_line_i, int_fault_i, svc_led_i;
  logic ext_fault_i, led_test_i, out_on_i, shutdown_evt_i, restart_done_i;
  logic iso_pass_i, iso_fail_i;
  logic [7:0] alarm_one_i, alarm_two_i, meas_curr_i, meas_temp_i;
  logic [15:0] default_vout_i, meas_vout_i, vout_set_o, ov_limit_o;
  logic [7:0] exp_b [10];
  int fails = 0;
  int checks_done = 0;

  // Open-drain data line with pull-up
  assign sda_w = ~(sda_pull | (sda_oe_o & ~sda_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  rps_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(sda_pull));

  rps_cmd_status DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .alert_oe_o(alert_oe_o), .addr_sel_i(addr_sel_i),
    .enable_pin_i(enable_pin_i), .default_vout_i(default_vout_i),
    .will_restart_i(will_restart_i), .high_line_i(high_line_i), .int_fault_i(int_fault_i),
    .svc_led_i(svc_led_i), .ext_fault_i(ext_fault_i), .led_test_i(led_test_i),
    .out_on_i(out_on_i), .shutdown_evt_i(shutdown_evt_i), .restart_done_i(restart_done_i),
    .iso_pass_i(iso_pass_i), .iso_fail_i(iso_fail_i), .alarm_one_i(alarm_one_i),
    .alarm_two_i(alarm_two_i), .meas_vout_i(meas_vout_i), .meas_curr_i(meas_curr_i),
    .meas_temp_i(meas_temp_i), .vout_set_o(vout_set_o), .ov_limit_o(ov_limit_o),
    .sw_setpoint_o(sw_setpoint_o)
  );

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // Bad flips checksum bits to provoke a refusal
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input int n,
                    input logic [15:0] d, input logic [7:0] bad);
    logic ack;
    host.start();
    host.wbyte(a, ack);
    check(ack, 16'h0001);
    host.wbyte(c, ack);
    if (n == 2) begin
      host.wbyte(d[7:0], ack);
      host.wbyte(d[15:8], ack);
    end
    host.wbyte(host.crc ^ bad, ack);
    host.stop();
  endtask : wr

  task automatic rd(input int n);
    logic ack;
    logic [7:0] b, p;
    host.start();
    host.wbyte(8'h8a, ack);
    host.wbyte(`RPS_CMD_RDSTAT, ack);
    host.rstart();
    host.wbyte(8'h8b, ack);
    check(ack, 16'h0001);
    for (int i = 0; i < n; i++) begin
      p = host.crc;
      host.rbyte(i == n - 1, b);
      check(b, (i == 9) ? p : exp_b[i]);
    end
    host.stop();
  endtask : rd

  initial begin
    wt(120000);
    fails++;
    results();
  end

  initial begin
    rst_n_i = 1'b0;
    addr_sel_i = 3'h5;
    enable_pin_i = 1'b1;
    default_vout_i = 16'h5460;
    will_restart_i = 1'b1;
    high_line_i = 1'b0;
    int_fault_i = 1'b0;
    svc_led_i = 1'b1;
    ext_fault_i = 1'b1;
    led_test_i = 1'b0;
    out_on_i = 1'b1;
    shutdown_evt_i = 1'b0;
    restart_done_i = 1'b0;
    iso_pass_i = 1'b0;
    iso_fail_i = 1'b0;
    alarm_one_i = 8'h00;
    alarm_two_i = 8'h00;
    meas_vout_i = 16'h5208;
    meas_curr_i = 8'h3c;
    meas_temp_i = 8'h29;
    wt(12);
    rst_n_i <= 1'b1;
    wt(10);
    check(vout_set_o, 16'h5460);
    check(ov_limit_o, `RPS_OV_RST);
    check(sw_setpoint_o, 16'h0000);
    // Alarm and shutdown before restart must vanish
    alarm_two_i <= 8'h81;
    shutdown_evt_i <= 1'b1;
    wt(1);
    alarm_two_i <= 8'h00;
    shutdown_evt_i <= 1'b0;
    wt(3);
    restart_done_i <= 1'b1;
    wt(1);
    restart_done_i <= 1'b0;
    wt(3);
    alarm_one_i <= 8'h24;
    iso_pass_i <= 1'b1;
    iso_fail_i <= 1'b1;
    wt(1);
    alarm_one_i <= 8'h00;
    iso_pass_i <= 1'b0;
    iso_fail_i <= 1'b0;
    wt(200);
    wr(`RPS_ADDR_BCAST, `RPS_CMD_VOUT, 2, `RPS_VOUT_MAX_CODE, 8'h00);
    check(vout_set_o, `RPS_VOUT_MAX_CODE);
    check(sw_setpoint_o, 16'h0001);
    default_vout_i <= 16'h4ed4;
    wt(4);
    check(vout_set_o, `RPS_VOUT_MAX_CODE);
    wr(8'h8a, `RPS_CMD_VOUT, 2, 16'h419f, 8'h00);
    check(vout_set_o, `RPS_VOUT_MAX_CODE);
    wr(8'h8a, `RPS_CMD_OVLIM, 2, 16'h5780, 8'h00);
    check(ov_limit_o, 16'h5780);
    wr(8'h8a, 8'hd2, 0, 16'h0000, 8'h00);
    check(alert_oe_o, 16'h0001);
    wr(8'h8a, `RPS_CMD_CLEAR, 0, 16'h0000, 8'h01);
    check(alert_oe_o, 16'h0001);
    // Status two: pec, restart armed, invalid, iso fail, restarted, range, enable
    exp_b = '{8'h09, 8'hef, 8'h4d, 8'h00, 8'h24, 8'h08, 8'h52, 8'h3c, 8'h29, 8'h00};
    rd(10);
    wr(8'h8a, `RPS_CMD_CLEAR, 0, 16'h0000, 8'h00);
    check(alert_oe_o, 16'h0000);
    enable_pin_i <= 1'b0;
    high_line_i <= 1'b1;
    int_fault_i <= 1'b1;
    svc_led_i <= 1'b0;
    ext_fault_i <= 1'b0;
    led_test_i <= 1'b1;
    out_on_i <= 1'b0;
    wt(10);
    exp_b = '{8'h09, 8'h50, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(3);
    results();
  end
endmodule : testbench
